/* File: acs_pkg.sv */
// Shared constants, enumerations and carrier structs for the axle count
// supervisor. Assumes a single 10 MHz system clock for all users.
package acs_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_HZ          = 10_000_000;
    localparam int WHEEL_MIN_US    = 100;
    localparam int WHEEL_MIN_CYC   =
        (WHEEL_MIN_US * CLK_HZ + 999_999) / 1_000_000;
    localparam int WHEEL_W         = $clog2(WHEEL_MIN_CYC + 1);
    localparam logic [WHEEL_W-1:0] WHEEL_LAST =
        WHEEL_W'(WHEEL_MIN_CYC - 1);
    localparam int PEER_TIMEOUT_MS = 500;
    localparam int PEER_TIMEOUT_CYC_DEF = (CLK_HZ / 1000) * PEER_TIMEOUT_MS;

    // ****************************************************************
    // Sizes and counts
    // ****************************************************************
    localparam int CNT_W    = 12;
    localparam int TOT_W    = CNT_W + 2;
    localparam int NUM_CH   = 2;
    localparam int NUM_PEER = 3;
    localparam int SYNC_W   = 12;
    localparam logic [CNT_W-1:0] CNT_MAX  = 12'hfff;
    localparam int ROCK_W   = 3;
    localparam logic [ROCK_W-1:0] ROCK_SINGLE = 3'h2;
    localparam logic [ROCK_W-1:0] ROCK_BOTH   = 3'h4;
    localparam logic [2:0] POINTS_PREP = 3'h2;

    // Bit positions inside the synchronised pin vector
    localparam int SY_SENS   = 0;
    localparam int SY_SOK    = 4;
    localparam int SY_CARD   = 8;
    localparam int SY_SUPPLY = 10;
    localparam int SY_RESET  = 11;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [2:0] {
        FLT_NONE     = 3'h0,
        FLT_SUPPLY   = 3'h1,
        FLT_CARD     = 3'h2,
        FLT_SENSOR   = 3'h3,
        FLT_ROCK     = 3'h4,
        FLT_PEER     = 3'h5,
        FLT_OVERFLOW = 3'h6,
        FLT_OUTFIRST = 3'h7
    } acs_fault_e;

    typedef enum logic [1:0] {
        CH_ERR  = 2'h0,
        CH_PREP = 2'h1,
        CH_RUN  = 2'h3
    } acs_chan_e;

    typedef enum logic [2:0] {
        DET_IDLE   = 3'h0,
        DET_A_IN   = 3'h1,
        DET_AB_IN  = 3'h3,
        DET_B_IN   = 3'h2,
        DET_B_OUT  = 3'h4,
        DET_BA_OUT = 3'h5,
        DET_A_OUT  = 3'h7
    } acs_det_e;

    typedef struct packed {
        logic [CNT_W-1:0] inCnt;
        logic [CNT_W-1:0] outCnt;
    } acs_count_s;

    typedef struct packed {
        acs_count_s cnt;
        logic       healthy;
    } acs_peer_s;

    typedef struct packed {
        acs_chan_e  state;
        acs_count_s cnt;
        acs_fault_e fault;
    } acs_chan_s;

endpackage

/* File: acs_axle_detector.sv */
// One detection point: filters two wheel sensor levels, finds direction
// and emits one-cycle in/out count pulses; flags rocking wheels.
// Assumes sensor levels are already synchronised to sys_clk.
`timescale 1ns/1ps
module acs_axle_detector (
    input  wire logic sys_clk,
    input  wire logic rstn,
    input  wire logic sensA,
    input  wire logic sensB,
    input  wire logic clrErr,
    output logic      inPulse,
    output logic      outPulse,
    output logic      rockErr
);
    import acs_pkg::*;

    logic [WHEEL_W-1:0] cntA, cntB, next_cntA, next_cntB;
    logic               occA, occB, next_occA, next_occB;
    acs_det_e           state, next_state;
    logic [ROCK_W-1:0]  rockA, rockB, rockAll;
    logic [ROCK_W-1:0]  next_rockA, next_rockB, next_rockAll, allSum;
    logic               next_inPulse, next_outPulse, next_rockErr;
    logic               riseA, riseB, countDone, rockHit;
    logic [1:0]         lvl;

    function automatic logic [WHEEL_W-1:0] stepFilt(
        input logic s, input logic [WHEEL_W-1:0] c);
        if (!s)
            return WHEEL_W'(0);
        else if (c == WHEEL_LAST)
            return c;
        else
            return c + WHEEL_W'(1);
    endfunction

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        // Short pulses from light trolley wheels never become occupancy
        next_cntA = stepFilt(sensA, cntA);
        next_cntB = stepFilt(sensB, cntB);
        next_occA = sensA && (occA || cntA == WHEEL_LAST);
        next_occB = sensB && (occB || cntB == WHEEL_LAST);
        riseA = next_occA & ~occA;
        riseB = next_occB & ~occB;
        lvl = {occA, occB};
        next_state = state;
        next_inPulse = 1'b0;
        next_outPulse = 1'b0;
        // Direction from the sensor hit first; count once both sensors clear after the far one
        unique case (state)
            DET_IDLE: begin
                if (lvl == 2'h2) next_state = DET_A_IN;
                else if (lvl == 2'h1) next_state = DET_B_OUT;
            end
            DET_A_IN: begin
                if (lvl == 2'h3) next_state = DET_AB_IN;
                else if (lvl != 2'h2) next_state = DET_IDLE;
            end
            DET_AB_IN: begin
                if (lvl == 2'h1) next_state = DET_B_IN;
                else if (lvl == 2'h2) next_state = DET_A_IN;
                else if (lvl == 2'h0) next_state = DET_IDLE;
            end
            DET_B_IN: begin
                if (lvl == 2'h0) begin
                    next_state = DET_IDLE;
                    next_inPulse = 1'b1;
                end
                else if (lvl == 2'h3) next_state = DET_AB_IN;
                else if (lvl == 2'h2) next_state = DET_IDLE;
            end
            DET_B_OUT: begin
                if (lvl == 2'h3) next_state = DET_BA_OUT;
                else if (lvl != 2'h1) next_state = DET_IDLE;
            end
            DET_BA_OUT: begin
                if (lvl == 2'h2) next_state = DET_A_OUT;
                else if (lvl == 2'h1) next_state = DET_B_OUT;
                else if (lvl == 2'h0) next_state = DET_IDLE;
            end
            DET_A_OUT: begin
                if (lvl == 2'h0) begin
                    next_state = DET_IDLE;
                    next_outPulse = 1'b1;
                end
                else if (lvl == 2'h3) next_state = DET_BA_OUT;
                else if (lvl == 2'h1) next_state = DET_IDLE;
            end
            default: next_state = DET_IDLE;
        endcase
        countDone = next_inPulse | next_outPulse;
        allSum = rockAll + ROCK_W'(riseA) + ROCK_W'(riseB);
        rockHit = (riseA && rockA >= ROCK_SINGLE - 3'h1) ||
                  (riseB && rockB >= ROCK_SINGLE - 3'h1) ||
                  (allSum >= ROCK_BOTH);
        if (clrErr || countDone) begin
            next_rockA = ROCK_W'(0);
            next_rockB = ROCK_W'(0);
            next_rockAll = ROCK_W'(0);
        end
        else begin
            next_rockA = (rockA >= ROCK_SINGLE) ? rockA :
                         rockA + ROCK_W'(riseA);
            next_rockB = (rockB >= ROCK_SINGLE) ? rockB :
                         rockB + ROCK_W'(riseB);
            next_rockAll = (allSum > ROCK_BOTH) ? ROCK_BOTH : allSum;
        end
        // A new rocking hit wins over a clear in the same cycle
        next_rockErr = (rockErr && !clrErr) || rockHit;
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cntA <= WHEEL_W'(0);
            cntB <= WHEEL_W'(0);
            occA <= 1'b0;
            occB <= 1'b0;
            state <= DET_IDLE;
            rockA <= ROCK_W'(0);
            rockB <= ROCK_W'(0);
            rockAll <= ROCK_W'(0);
            inPulse <= 1'b0;
            outPulse <= 1'b0;
            rockErr <= 1'b0;
        end
        else begin
            cntA <= next_cntA;
            cntB <= next_cntB;
            occA <= next_occA;
            occB <= next_occB;
            state <= next_state;
            rockA <= next_rockA;
            rockB <= next_rockB;
            rockAll <= next_rockAll;
            inPulse <= next_inPulse;
            outPulse <= next_outPulse;
            rockErr <= next_rockErr;
        end
    end

endmodule

/* File: acs_axle_count_supervisor.sv */
// Field unit of a single section axle counter, one or two channels.
// Assumes peer messages arrive already decoded on sys_clk; all pins are
// asynchronous and pass a three-stage synchroniser.
//
// Operation
// - Clear only when total in equals total out and all supervision healthy.
// - Any faulty or missing sub-assembly forces occupied at once.
// - Continuous self-check; any failure or supply loss drops clear.
// - Sensor or cable defect gives an error code and error mode at once.
// - Axle counters hold at least 1024 axles without loss.
// - Entering train turns section occupied in under one second.
// - Section reported clear under 2.5 seconds after last axle leaves.
// - One sensor hit twice without a valid count gives error.
// - Both sensors hit four times without a valid count gives error.
// - Simultaneous in and out axles both counted, none lost.
// - Count, find direction, compare, drive vital output, send counts.
// - Light trolley wheels are neither counted nor cause error.
// - Per card failure, total failure and healthy indications with cause.
// - One to four detection points per section supported.
// - Sampling fast enough for trains up to 250 km/h.
// - Two channels each drive a vital output; section state is their OR.
// - Healthy channel auto-resets a failed companion in steady state.
// - One reset to both channels, taken only while own output dropped.
// - Channels share one sensor input or use separate ones.
// - Free and occupied shown as picked-up and dropped vital output.
// - Out count before any in count holds error until reset.
`timescale 1ns/1ps
module acs_axle_count_supervisor #(
    parameter int PEER_TIMEOUT_CYC = acs_pkg::PEER_TIMEOUT_CYC_DEF
) (
    input  wire logic                           sys_clk,
    input  wire logic                           rstn,
    input  wire logic [3:0]                     sensPin,
    input  wire logic [3:0]                     sensorOkPin,
    input  wire logic [1:0]                     cardOkPin,
    input  wire logic                           supplyOkPin,
    input  wire logic                           resetCmdPin,
    input  wire logic [2:0]                     numPoints,
    input  wire logic                           dualMode,
    input  wire logic                           sensorShared,
    input  wire acs_pkg::acs_peer_s [2:0]       peerMsg,
    input  wire logic [2:0]                     peerStrobe,
    output logic [1:0]                          vital,
    output logic                                vitalOr,
    output logic [1:0]                          prepState,
    output acs_pkg::acs_fault_e [1:0]           failCode,
    output logic [1:0]                          cardFail,
    output logic                                sysFail,
    output logic                                sysOk,
    output acs_pkg::acs_peer_s [1:0]            txMsg
);
    import acs_pkg::*;

    // Peer age saturates at the timeout, so it never wraps back to fresh
    localparam int PT_W = $clog2(PEER_TIMEOUT_CYC + 1);
    localparam logic [PT_W-1:0] PT_LAST = PT_W'(PEER_TIMEOUT_CYC);

    // ****************************************************************
    // Pin synchroniser
    // ****************************************************************
    logic [SYNC_W-1:0] syn1, syn2, syn3, pins, next_pins;
    logic              rstLvl, next_rstLvl;

    // A bit changes only once the second and third stage agree
    always_comb begin
        next_pins = (pins & (syn2 ^ syn3)) | (syn3 & ~(syn2 ^ syn3));
        next_rstLvl = pins[SY_RESET];
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            syn1 <= SYNC_W'(0);
            syn2 <= SYNC_W'(0);
            syn3 <= SYNC_W'(0);
            pins <= SYNC_W'(0);
            rstLvl <= 1'b0;
        end
        else begin
            syn1 <= {resetCmdPin, supplyOkPin, cardOkPin, sensorOkPin,
                     sensPin};
            syn2 <= syn1;
            syn3 <= syn2;
            pins <= next_pins;
            rstLvl <= next_rstLvl;
        end
    end

    // ****************************************************************
    // Detection points, one per channel
    // ****************************************************************
    logic [1:0] inPulse, outPulse, rockErr, clrErr;
    logic [3:0] sensSel;

    // Shared mode feeds channel 0 sensors to both channels
    assign sensSel = sensorShared ?
        {pins[SY_SENS+1:SY_SENS], pins[SY_SENS+1:SY_SENS]} :
        pins[SY_SENS+3:SY_SENS];

    for (genvar g = 0; g < NUM_CH; g++) begin : gDet
        acs_axle_detector uDet (
            .sys_clk  (sys_clk),
            .rstn     (rstn),
            .sensA    (sensSel[2*g]),
            .sensB    (sensSel[2*g+1]),
            .clrErr   (clrErr[g]),
            .inPulse  (inPulse[g]),
            .outPulse (outPulse[g]),
            .rockErr  (rockErr[g])
        );
    end

    // ****************************************************************
    // Peer messages and freshness
    // ****************************************************************
    acs_peer_s [2:0] peerHeld, next_peerHeld;
    logic [PT_W-1:0] peerAge [NUM_PEER];
    logic [PT_W-1:0] next_peerAge [NUM_PEER];
    logic [2:0]      peerUsed, peerBad;

    always_comb begin
        for (int p = 0; p < NUM_PEER; p++) begin
            next_peerHeld[p] = peerStrobe[p] ? peerMsg[p] : peerHeld[p];
            next_peerAge[p] = peerStrobe[p] ? PT_W'(0) :
                (peerAge[p] == PT_LAST) ? peerAge[p] : peerAge[p] + PT_W'(1);
            // Points beyond the first are peers
            peerUsed[p] = (3'(p) + 3'h1) < numPoints;
            peerBad[p] = peerUsed[p] &&
                (peerAge[p] == PT_LAST || !peerHeld[p].healthy);
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            // Peers start stale so old data cannot clear the section
            peerHeld <= '0;
            for (int p = 0; p < NUM_PEER; p++)
                peerAge[p] <= PT_LAST;
        end
        else begin
            peerHeld <= next_peerHeld;
            for (int p = 0; p < NUM_PEER; p++)
                peerAge[p] <= next_peerAge[p];
        end
    end

    // ****************************************************************
    // Channel supervision
    // ****************************************************************
    acs_chan_s [1:0]  chan, next_chan;
    logic [1:0]       next_vital, next_prep, next_card, next_clr, chanOn;
    logic             next_vitalOr, next_sysFail, next_sysOk;
    acs_fault_e [1:0] live;
    acs_peer_s [1:0]  next_tx;
    logic [TOT_W-1:0] totIn, totOut, nTotIn, nTotOut;
    logic             rstEdge, ovf, outFirst;

    // Section total over the local count and every peer in use
    function automatic logic [TOT_W-1:0] sectionSum(
        input logic [CNT_W-1:0] own, input acs_peer_s [2:0] pm,
        input logic [2:0] use_, input logic selOut);
        logic [TOT_W-1:0] s;
        s = TOT_W'(own);
        for (int p = 0; p < NUM_PEER; p++)
            if (use_[p])
                s = s + TOT_W'(selOut ? pm[p].cnt.outCnt : pm[p].cnt.inCnt);
        return s;
    endfunction

    always_comb begin
        // One press gives one edge, however long the key is held
        rstEdge = pins[SY_RESET] && !rstLvl;
        next_chan = chan;
        next_clr = 2'h0;
        for (int c = 0; c < NUM_CH; c++) begin
            // Channel 1 exists only in the dual channel variant
            chanOn[c] = (c == 0) || dualMode;
            next_card[c] = chanOn[c] && !pins[SY_CARD+c];
            // Fixed priority picks the reported cause of failure
            if (!pins[SY_SUPPLY])
                live[c] = FLT_SUPPLY;
            else if (!pins[SY_CARD+c])
                live[c] = FLT_CARD;
            else if (pins[SY_SOK+2*c+1 -: 2] != 2'h3)
                live[c] = FLT_SENSOR;
            // A rocking flag that this channel's reset is clearing is stale
            else if (rockErr[c] && !clrErr[c])
                live[c] = FLT_ROCK;
            else if (peerBad != 3'h0)
                live[c] = FLT_PEER;
            else
                live[c] = FLT_NONE;
            totIn = sectionSum(chan[c].cnt.inCnt, peerHeld, peerUsed, 1'b0);
            totOut = sectionSum(chan[c].cnt.outCnt, peerHeld, peerUsed, 1'b1);
            ovf = (inPulse[c] && chan[c].cnt.inCnt == CNT_MAX) ||
                  (outPulse[c] && chan[c].cnt.outCnt == CNT_MAX);
            // An out axle with nothing inside means a missed in count
            outFirst = outPulse[c] && !inPulse[c] && totIn == TOT_W'(0);
            unique case (chan[c].state)
                CH_ERR: begin
                    // Counts restart at zero; a live section is never reset
                    if (chanOn[c] && rstEdge && !vital[c]) begin
                        next_clr[c] = 1'b1;
                        next_chan[c].cnt = '0;
                        next_chan[c].fault = FLT_NONE;
                        next_chan[c].state = (numPoints == POINTS_PREP) ?
                            CH_PREP : CH_RUN;
                    end
                    // Companion clear and stable takes this channel back
                    else if (chanOn[c] && dualMode && live[c] == FLT_NONE &&
                             chan[1-c].state == CH_RUN && vital[1-c]) begin
                        next_clr[c] = 1'b1;
                        next_chan[c].cnt = chan[1-c].cnt;
                        next_chan[c].fault = FLT_NONE;
                        next_chan[c].state = CH_RUN;
                    end
                end
                CH_PREP, CH_RUN: begin
                    // Both directions update in the same cycle
                    next_chan[c].cnt.inCnt =
                        chan[c].cnt.inCnt + CNT_W'(inPulse[c]);
                    next_chan[c].cnt.outCnt =
                        chan[c].cnt.outCnt + CNT_W'(outPulse[c]);
                    if (!chanOn[c] || live[c] != FLT_NONE) begin
                        next_chan[c].state = CH_ERR;
                        next_chan[c].fault = chanOn[c] ? live[c] : FLT_CARD;
                    end
                    else if (ovf) begin
                        next_chan[c].state = CH_ERR;
                        next_chan[c].fault = FLT_OVERFLOW;
                    end
                    else if (outFirst) begin
                        next_chan[c].state = CH_ERR;
                        next_chan[c].fault = FLT_OUTFIRST;
                    end
                    else if (chan[c].state == CH_PREP &&
                             totIn != TOT_W'(0) && totIn == totOut)
                        next_chan[c].state = CH_RUN;
                end
                // An upset state code is treated as a failed channel
                default: begin
                    next_chan[c].state = CH_ERR;
                    next_chan[c].fault = FLT_CARD;
                end
            endcase
            nTotIn = sectionSum(next_chan[c].cnt.inCnt, peerHeld, peerUsed,
                                1'b0);
            nTotOut = sectionSum(next_chan[c].cnt.outCnt, peerHeld, peerUsed,
                                 1'b1);
            // Evaluated every cycle, so clear and occupied follow at once
            next_vital[c] = next_chan[c].state == CH_RUN &&
                            live[c] == FLT_NONE &&
                            nTotIn == nTotOut;
            next_prep[c] = next_chan[c].state == CH_PREP;
            next_tx[c].cnt = next_chan[c].cnt;
            next_tx[c].healthy = chanOn[c] && live[c] == FLT_NONE &&
                                 next_chan[c].state != CH_ERR;
        end
        next_vitalOr = |next_vital;
        // System failure only when every enabled channel is down
        next_sysFail = (next_chan[0].state == CH_ERR) &&
                       (!dualMode || next_chan[1].state == CH_ERR);
        next_sysOk = next_tx[0].healthy &&
                     (!dualMode || next_tx[1].healthy);
    end

    // Power-up lands in error: a reset command is needed before clear
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            for (int c = 0; c < NUM_CH; c++) begin
                chan[c].state <= CH_ERR;
                chan[c].cnt <= '0;
                chan[c].fault <= FLT_SUPPLY;
            end
            clrErr <= 2'h0;
            vital <= 2'h0;
            vitalOr <= 1'b0;
            prepState <= 2'h0;
            cardFail <= 2'h0;
            sysFail <= 1'b1;
            sysOk <= 1'b0;
            txMsg <= '0;
        end
        else begin
            chan <= next_chan;
            clrErr <= next_clr;
            vital <= next_vital;
            vitalOr <= next_vitalOr;
            prepState <= next_prep;
            cardFail <= next_card;
            sysFail <= next_sysFail;
            sysOk <= next_sysOk;
            txMsg <= next_tx;
        end
    end

    // Fault code holds until a reset or an auto-reset clears it
    always_comb begin
        for (int c = 0; c < NUM_CH; c++)
            failCode[c] = chan[c].fault;
    end

endmodule

/* File: acs_peer_model.sv */
// Peer unit model: healthy, zero counts, strobed every 64 cycles.
// Assumes the unit samples peer data only on the strobe pulse.
`timescale 1ns/1ps
module acs_peer_model (
    input  wire logic          sys_clk,
    input  wire logic          rstn,
    output acs_pkg::acs_peer_s msg,
    output logic               strobe
);
    import acs_pkg::*;
    logic [5:0] tick;
    always_ff @(posedge sys_clk or negedge rstn)
        if (!rstn)
            tick <= 6'h0;
        else
            tick <= tick + 6'h1;
    assign strobe = &tick;
    // Data toggles between strobes so stale data cannot pass as fresh
    assign msg = strobe ? 25'h1 : {25{tick[0]}};
endmodule

/* File: acs_checker_properties.sv */
// Port checker for the axle count supervisor, channel 0.
// Assumes one clock domain; bound to the top module below.
`timescale 1ns/1ps
module acs_checker (
    input wire logic                      sys_clk,
    input wire logic                      rstn,
    input wire logic [3:0]                sensorOkPin,
    input wire logic [1:0]                cardOkPin,
    input wire logic                      supplyOkPin,
    input wire logic [1:0]                vital,
    input wire logic                      vitalOr,
    input wire acs_pkg::acs_fault_e [1:0] failCode,
    input wire logic                      sysFail,
    input wire logic                      sysOk,
    input wire acs_pkg::acs_peer_s [1:0]  txMsg
);
    import acs_pkg::*;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    sequence s_lost(x); !x [*4]; endsequence
    property p_or; vitalOr == |vital; endproperty
    a_or: assert property (p_or) else $error("or");
    property p_flt; failCode[0] != FLT_NONE |-> !vital[0]; endproperty
    a_flt: assert property (p_flt) else $error("flt");
    property p_sup; s_lost(supplyOkPin) |-> ##[0:6] !vital[0]; endproperty
    a_sup: assert property (p_sup) else $error("sup");
    property p_card; s_lost(cardOkPin[0]) |-> ##[0:6] !vital[0]; endproperty
    a_card: assert property (p_card) else $error("card");
    property p_sen; s_lost(sensorOkPin[0]) |-> ##[0:6] !vital[0]; endproperty
    a_sen: assert property (p_sen) else $error("sen");
    property p_rise; $rose(vital[0]) |->
        txMsg[0].cnt.inCnt == txMsg[0].cnt.outCnt; endproperty
    a_rise: assert property (p_rise) else $error("rise");
    property p_tx; $changed(txMsg[0].cnt.inCnt) |-> txMsg[0].cnt.inCnt ==
        $past(txMsg[0].cnt.inCnt) + 12'h1 || txMsg[0].cnt.inCnt == 0;
    endproperty
    a_tx: assert property (p_tx) else $error("tx");
    property p_ok; sysOk |-> !sysFail; endproperty
    a_ok: assert property (p_ok) else $error("ok");
endmodule
bind acs_axle_count_supervisor acs_checker u_chk (.sys_clk, .rstn,
    .sensorOkPin, .cardOkPin, .supplyOkPin, .vital, .vitalOr, .failCode,
    .sysFail, .sysOk, .txMsg);

/* File: acs_axle_count_supervisor_tb.sv */
// Bench for the supervisor: single and dual channel, one and two detection points.
// Assumes the peer model and the checker are compiled first.
`timescale 1ns/1ps
module acs_axle_count_supervisor_tb;
    import acs_pkg::*;
    logic             sys_clk = 1'b0;
    logic             rstn, supplyOkPin, resetCmdPin, pStb;
    logic             dualMode, sensorShared, vitalOr, sysFail, sysOk;
    logic [3:0]       sensPin, sensorOkPin;
    logic [1:0]       cardOkPin, vital, prepState, cardFail;
    logic [2:0]       numPoints;
    acs_fault_e [1:0] failCode;
    acs_peer_s [1:0]  txMsg;
    acs_peer_s        pMsg;
    int               n_errors = 0;
    int               tests_run = 0;
    acs_peer_model peer (.sys_clk, .rstn, .msg(pMsg), .strobe(pStb));
    acs_axle_count_supervisor #(.PEER_TIMEOUT_CYC(200)) dut (.sys_clk,
        .rstn, .sensPin, .sensorOkPin, .cardOkPin, .supplyOkPin,
        .resetCmdPin, .numPoints, .dualMode, .sensorShared,
        .peerMsg({3{pMsg}}), .peerStrobe({3{pStb}}), .vital, .vitalOr,
        .prepState, .failCode, .cardFail, .sysFail, .sysOk, .txMsg);
    task check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task cyc(input int n); repeat (n) @(negedge sys_clk); endtask
    task pins(input logic [1:0] v, input int n);
        sensPin[1:0] = v;
        cyc(n);
    endtask
    task press;
        resetCmdPin = 1'b1;
        cyc(10);
        resetCmdPin = 1'b0;
        cyc(2);
    endtask
    // Each occupied phase outlasts the wheel filter so the axle is taken
    task pass(input logic [1:0] a, input logic [1:0] b);
        pins(a, 1100);
        pins(2'h3, 1100);
        pins(b, 1100);
        pins(2'h0, 10);
    endtask
    task t_axles;
        check(failCode[0], FLT_SUPPLY);
        press();
        check(vital, 2'h1);
        pass(2'h1, 2'h2);
        check(txMsg[0].cnt, {12'h1, 12'h0});
        check(vital[0], 1'b0);
        pass(2'h2, 2'h1);
        check(txMsg[0].cnt, {12'h1, 12'h1});
        check(vital[0], 1'b1);
    endtask
    task t_trolley_rock;
        pins(2'h1, 200);
        pins(2'h0, 20);
        check(failCode[0], FLT_NONE);
        pins(2'h1, 1100);
        pins(2'h0, 1100);
        pins(2'h1, 1100);
        pins(2'h0, 10);
        check(failCode[0], FLT_ROCK);
    endtask
    task t_faults;
        acs_fault_e want [3] = '{FLT_SENSOR, FLT_CARD, FLT_SUPPLY};
        for (int i = 0; i < 3; i++) begin
            press();
            {supplyOkPin, cardOkPin[0], sensorOkPin[0]} = ~(3'h1 << i);
            cyc(10);
            check(failCode[0], want[i]);
            {supplyOkPin, cardOkPin[0], sensorOkPin[0]} = 3'h7;
            cyc(10);
        end
    endtask
    task t_dual;
        numPoints = 3'h2;
        press();
        check({prepState, vital}, 4'h4);
        cardOkPin[0] = 1'b0;
        cyc(10);
        {cardOkPin[0], numPoints, dualMode, sensorShared} = 6'h27;
        press();
        check({vital, vitalOr}, 3'h7);
        cardOkPin[1] = 1'b0;
        cyc(10);
        check({cardFail, vital, vitalOr, failCode[1]}, 8'h9a);
        cardOkPin[1] = 1'b1;
        cyc(10);
        check({vital, sysOk, sysFail}, 4'he);
        {dualMode, sensorShared} = 2'h0;
        cyc(4);
    endtask
    task report_and_stop;
        if (n_errors == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        forever #50 sys_clk = ~sys_clk;
    end
    initial begin
        cyc(30000);
        n_errors++;
        report_and_stop();
    end
    initial begin
        {rstn, resetCmdPin, dualMode, sensorShared, sensPin} = 8'h0;
        {supplyOkPin, cardOkPin, sensorOkPin} = 7'h7f;
        numPoints = 3'h1;
        cyc(3);
        rstn = 1'b1;
        cyc(5);
        t_axles();
        t_trolley_rock();
        t_faults();
        t_dual();
        report_and_stop();
    end
endmodule
